// File: design/fpu_pkg.sv
// =====================================================================
// shared constants of the floating format and normalize unit
// =====================================================================
package fpu_pkg;

   // register byte offsets on the plain register port
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_OPA_HI = 5'h04;
   localparam logic [4:0] OFF_OPA_LO = 5'h08;
   localparam logic [4:0] OFF_OPB_HI = 5'h0C;
   localparam logic [4:0] OFF_OPB_LO = 5'h10;
   localparam logic [4:0] OFF_CMD    = 5'h14;
   localparam logic [4:0] OFF_RES_HI = 5'h18;
   localparam logic [4:0] OFF_RES_LO = 5'h1C;

   // status register field positions
   localparam int IEN_DISABLE_BIT = 14;
   localparam int IEN_UNDEF_BIT   = 11;
   localparam int IEN_UFL_BIT     = 10;
   localparam int IEN_OVF_BIT     = 9;
   localparam int IEN_CVT_BIT     = 8;
   localparam int DBL_BIT         = 7;
   localparam int LONG_BIT        = 6;
   localparam int TRUNC_BIT       = 5;
   localparam int CC_N            = 3;
   localparam int CC_Z            = 2;
   localparam int CC_V            = 1;
   localparam int CC_C            = 0;

   // values after reset
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [4:0] IEN_RST  = 5'h00;
   localparam logic [3:0] CC_RST   = 4'h0;

   // exponent handling, true exponents held as 11-bit signed values
   localparam logic signed [10:0] EXP_BIAS   = 11'sh080;
   localparam logic signed [10:0] EXP_MAX    = 11'sh07F;
   localparam logic signed [10:0] EXP_MIN_NZ = 11'sh781;
   localparam logic signed [10:0] INT_EXP    = 11'sh020;
   localparam logic signed [10:0] INT_LIM_L  = 11'sh01F;
   localparam logic signed [10:0] INT_LIM_S  = 11'sh00F;
   localparam logic signed [10:0] F2I_TOP    = 11'sh03F;

   // integer widths and rounding increments (half an lsb of the stored fraction)
   localparam int          SHORT_INT_W = 16;
   localparam int          LONG_INT_W  = 32;
   localparam logic [63:0] RND_SGL     = 64'h0000_0040_0000_0000;
   localparam logic [63:0] RND_DBL     = 64'h0000_0000_0000_0040;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_ALIGN = 3'b001,
      S_ARITH = 3'b010,
      S_NORM  = 3'b011
   } state_t;

   typedef enum logic [2:0] {
      OP_ADD = 3'b000,
      OP_SUB = 3'b001,
      OP_MUL = 3'b010,
      OP_DIV = 3'b011,
      OP_I2F = 3'b100,
      OP_F2I = 3'b101
   } op_t;

endpackage : fpu_pkg

// File: design/norm_shift.sv
`timescale 1ns/100ps
// =====================================================================
// normalizer: one right shift on overflow, else left shift to hidden bit
// =====================================================================
module norm_shift
   import fpu_pkg::*;
(
   input  wire logic        [63:0] frac_i,
   input  wire logic signed [10:0] exp_i,
   output logic             [63:0] frac_o,
   output logic signed      [10:0] exp_o,
   output logic                    zero_o
);

   logic [5:0] lz_cnt;
   logic       found;

   // leading zero count below the overflow bit
   always_comb begin
      lz_cnt = 6'h00;
      found  = 1'b0;
      for (int i = 62; i >= 0; i--) begin
         if (!found) begin
            if (frac_i[i]) begin
               found = 1'b1;
            end else begin
               lz_cnt = lz_cnt + 6'h01;
            end
         end
      end
   end

   // RULE1 RULE13 shift and adjust
   // overflow wins: a set bit 63 never needs a left shift
   always_comb begin
      if (frac_i[63]) begin
         frac_o = frac_i >> 1;
         exp_o  = exp_i + 11'sh001;
      end else begin
         frac_o = frac_i << lz_cnt;
         exp_o  = exp_i - $signed({5'h00, lz_cnt});
      end
   end

   assign zero_o = (frac_i == 64'h0);

endmodule : norm_shift

// File: design/float_format_normalize_unit.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: normalize by left shifts until bit 62 is one, exponent down per shift.
// RULE2: add/sub shifts smaller-exponent fraction right one step, exponent up, until equal.
// RULE3: multiply fractions and add exponents, no alignment.
// RULE4: divide fractions and subtract divisor exponent, no alignment.
// RULE5: integers come as 16-bit short or 32-bit long.
// RULE6: integers are two's complement, msb is the sign.
// RULE7: floats are 32-bit single or 64-bit double words.
// RULE8: float word: sign, 8-bit exponent, 23 or 55 fraction bits.
// RULE9: exponent field is true exponent plus 128.
// RULE10: an exponent field of zero means the value zero.
// RULE11: fraction is sign-magnitude, negation flips only the sign.
// RULE12: internal bit 63 is overflow, bit 62 hidden; normalized gives 01.
// RULE13: overflowed result shifts right once and exponent goes up one.
// RULE14: hidden bit dropped when packing, reinserted when unpacking.
// RULE15: operands and results only in short, long, single, double formats.
// RULE16: status holds N Z V C codes, three mode bits, interrupt enables.
// RULE17: double select chooses 64-bit float format, else 32-bit.
// RULE18: long select chooses 32-bit integers for conversions, else 16-bit.
// RULE19: truncate select truncates float results instead of rounding.
// RULE20: every arithmetic result is renormalized before it is stored.
module float_format_normalize_unit
   import fpu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [4:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   output logic             busy_o,
   output logic             done_o,
   output logic      [3:0]  cc_o
);

   // =================================================================
   // reset release
   // =================================================================
   logic rst_m_q;
   logic rst_b;

   // async assert, release through two flops
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_m_q <= 1'b0;
         rst_b   <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_b   <= rst_m_q;
      end
   end

   // =================================================================
   // declarations
   // =================================================================
   logic        [2:0]  mode_q;
   logic        [4:0]  ien_q;
   logic        [3:0]  cc_q;
   logic        [31:0] opa_hi_q, opa_lo_q, opb_hi_q, opb_lo_q;
   logic        [31:0] res_hi_q, res_lo_q, rdata_q;
   state_t             state_q;
   op_t                op_q;
   logic        [63:0] fa_q, fb_q, rf_q;
   logic signed [10:0] ea_q, eb_q, re_q;
   logic               sa_q, sb_q, rs_q, div0_q, done_q;
   logic               dbl, lng, trunc, start, valid_op;
   logic        [31:0] int_val, int_mag;
   logic        [127:0] prod;
   logic        [126:0] quot;
   logic        [5:0]  f2i_sh;
   logic        [63:0] f2i_mag;
   logic        [31:0] f2i_res;
   logic               f2i_err;
   logic        [63:0] nf, rnd, rsum, pf;
   logic signed [10:0] ne, pe;
   logic               nz, res_zero, res_ovf;
   logic        [7:0]  pfield;
   logic        [31:0] pk_hi, pk_lo;
   logic        [3:0]  cc_new;
   logic               cc_load;

   assign dbl   = mode_q[2];
   assign lng   = mode_q[1];
   assign trunc = mode_q[0];

   // RULE14 hidden insert
   function automatic logic [63:0] unpack_frac(input logic [31:0] hi,
                                               input logic [31:0] lo,
                                               input logic        d);
      logic [63:0] f;
      // RULE10 zero exponent
      if (hi[30:23] == 8'h00) begin
         f = 64'h0;
      // RULE12 overflow and hidden bits
      end else if (d) begin
         f = {2'b01, hi[22:0], lo, 7'h00};
      end else begin
         f = {2'b01, hi[22:0], 39'h0};
      end
      return f;
   endfunction : unpack_frac

   // RULE9 remove bias
   function automatic logic signed [10:0] unpack_exp(input logic [31:0] hi);
      return $signed({3'b000, hi[30:23]}) - EXP_BIAS;
   endfunction : unpack_exp

   // =================================================================
   // register port
   // =================================================================
   assign valid_op = (wdata_i[2:0] <= OP_F2I);
   assign start    = wr_i && (addr_i == OFF_CMD) && (state_q == S_IDLE) && valid_op;

   // operand words; writes land even while busy, operands were already captured
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         opa_hi_q <= 32'h0;
         opa_lo_q <= 32'h0;
         opb_hi_q <= 32'h0;
         opb_lo_q <= 32'h0;
      end else if (wr_i) begin
         if (addr_i == OFF_OPA_HI) begin
            opa_hi_q <= wdata_i;
         end else if (addr_i == OFF_OPA_LO) begin
            opa_lo_q <= wdata_i;
         end else if (addr_i == OFF_OPB_HI) begin
            opb_hi_q <= wdata_i;
         end else if (addr_i == OFF_OPB_LO) begin
            opb_lo_q <= wdata_i;
         end
      end
   end

   // RULE16 mode and enables
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= MODE_RST;
         ien_q  <= IEN_RST;
      end else if (wr_i && (addr_i == OFF_STATUS)) begin
         mode_q <= {wdata_i[DBL_BIT], wdata_i[LONG_BIT], wdata_i[TRUNC_BIT]};
         ien_q  <= {wdata_i[IEN_DISABLE_BIT], wdata_i[IEN_UNDEF_BIT],
                    wdata_i[IEN_UFL_BIT], wdata_i[IEN_OVF_BIT], wdata_i[IEN_CVT_BIT]};
      end
   end

   // RULE16 condition codes; a finishing operation wins over a software write
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         cc_q <= CC_RST;
      end else if (cc_load) begin
         cc_q <= cc_new;
      end else if (wr_i && (addr_i == OFF_STATUS)) begin
         cc_q <= wdata_i[3:0];
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0;
      end else if (!rd_i) begin
         rdata_q <= 32'h0;
      end else if (addr_i == OFF_STATUS) begin
         rdata_q <= {17'h0, ien_q[4], 2'b00, ien_q[3:0], mode_q, 1'b0, cc_q};
      end else if (addr_i == OFF_OPA_HI) begin
         rdata_q <= opa_hi_q;
      end else if (addr_i == OFF_OPA_LO) begin
         rdata_q <= opa_lo_q;
      end else if (addr_i == OFF_OPB_HI) begin
         rdata_q <= opb_hi_q;
      end else if (addr_i == OFF_OPB_LO) begin
         rdata_q <= opb_lo_q;
      end else if (addr_i == OFF_CMD) begin
         rdata_q <= {31'h0, (state_q != S_IDLE)};
      end else if (addr_i == OFF_RES_HI) begin
         rdata_q <= res_hi_q;
      end else if (addr_i == OFF_RES_LO) begin
         rdata_q <= res_lo_q;
      end else begin
         rdata_q <= 32'h0;
      end
   end

   // =================================================================
   // sequencer
   // =================================================================
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
         op_q    <= OP_ADD;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  op_q <= op_t'(wdata_i[2:0]);
                  if (wdata_i[2:0] <= OP_SUB) begin
                     state_q <= S_ALIGN;
                  end else if (wdata_i[2:0] == OP_I2F) begin
                     state_q <= S_NORM;
                  end else begin
                     state_q <= S_ARITH;
                  end
               end
            end
            S_ALIGN: begin
               if (ea_q == eb_q) begin
                  state_q <= S_ARITH;
               end
            end
            S_ARITH: begin
               state_q <= (op_q == OP_F2I) ? S_IDLE : S_NORM;
            end
            S_NORM: begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // =================================================================
   // datapath
   // =================================================================
   // RULE6 sign extension
   assign int_val = lng ? opa_hi_q : {{SHORT_INT_W{opa_hi_q[15]}}, opa_hi_q[15:0]};
   assign int_mag = int_val[31] ? (32'h0 - int_val) : int_val;
   // RULE3 fraction product
   assign prod    = {64'h0, fa_q} * {64'h0, fb_q};
   // RULE4 fraction quotient, guarded against a zero divisor
   assign quot    = {fa_q, 63'h0} / {63'h0, ((fb_q == 64'h0) ? 64'h1 : fb_q)};

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         fa_q   <= 64'h0;
         fb_q   <= 64'h0;
         ea_q   <= 11'sh000;
         eb_q   <= 11'sh000;
         sa_q   <= 1'b0;
         sb_q   <= 1'b0;
         rf_q   <= 64'h0;
         re_q   <= 11'sh000;
         rs_q   <= 1'b0;
         div0_q <= 1'b0;
      end else if (state_q == S_IDLE) begin
         if (start) begin
            // RULE17 format select
            fa_q   <= unpack_frac(opa_hi_q, opa_lo_q, dbl);
            fb_q   <= unpack_frac(opb_hi_q, opb_lo_q, dbl);
            ea_q   <= unpack_exp(opa_hi_q);
            eb_q   <= unpack_exp(opb_hi_q);
            sa_q   <= opa_hi_q[31];
            // RULE11 negate by sign
            sb_q   <= opb_hi_q[31] ^ (wdata_i[2:0] == OP_SUB);
            div0_q <= 1'b0;
            // RULE18 integer source
            rf_q   <= {1'b0, int_mag, 31'h0};
            re_q   <= INT_EXP;
            rs_q   <= int_val[31];
         end
      end else if (state_q == S_ALIGN) begin
         // a zero fraction just adopts the other exponent
         if (fa_q == 64'h0) begin
            ea_q <= eb_q;
         end else if (fb_q == 64'h0) begin
            eb_q <= ea_q;
         // RULE2 align one step
         end else if (ea_q < eb_q) begin
            fa_q <= fa_q >> 1;
            ea_q <= ea_q + 11'sh001;
         end else if (eb_q < ea_q) begin
            fb_q <= fb_q >> 1;
            eb_q <= eb_q + 11'sh001;
         end
      end else if (state_q == S_ARITH) begin
         if (op_q == OP_MUL) begin
            // RULE3 exponent sum
            rf_q <= prod[126:63];
            re_q <= ea_q + eb_q;
            rs_q <= sa_q ^ sb_q;
         end else if (op_q == OP_DIV) begin
            // RULE4 exponent difference
            rf_q   <= (fb_q == 64'h0) ? 64'h0 : quot[63:0];
            re_q   <= ea_q - eb_q;
            rs_q   <= sa_q ^ sb_q;
            div0_q <= (fb_q == 64'h0);
         end else begin
            re_q <= ea_q;
            if (sa_q == sb_q) begin
               rf_q <= fa_q + fb_q;
               rs_q <= sa_q;
            end else if (fa_q >= fb_q) begin
               rf_q <= fa_q - fb_q;
               rs_q <= sa_q;
            end else begin
               rf_q <= fb_q - fa_q;
               rs_q <= sb_q;
            end
         end
      end
   end

   // float to integer, truncating toward zero; out of range is an error
   assign f2i_sh  = 6'(F2I_TOP - ea_q);
   assign f2i_mag = fa_q >> f2i_sh;
   assign f2i_err = (fa_q != 64'h0) && (ea_q > (lng ? INT_LIM_L : INT_LIM_S));
   // RULE5 integer widths
   always_comb begin
      if (f2i_err || (fa_q == 64'h0) || (ea_q <= 11'sh000)) begin
         f2i_res = 32'h0;
      end else if (lng) begin
         f2i_res = sa_q ? (32'h0 - f2i_mag[31:0]) : f2i_mag[31:0];
      end else begin
         f2i_res = {16'h0, (sa_q ? (16'h0 - f2i_mag[15:0]) : f2i_mag[15:0])};
      end
   end

   // RULE20 renormalize result
   norm_shift u_norm (
      .frac_i (rf_q),
      .exp_i  (re_q),
      .frac_o (nf),
      .exp_o  (ne),
      .zero_o (nz)
   );

   // RULE19 truncate or round
   assign rnd  = trunc ? 64'h0 : (dbl ? RND_DBL : RND_SGL);
   assign rsum = nf + rnd;
   // RULE13 rounding carry
   assign pf   = rsum[63] ? (rsum >> 1) : rsum;
   assign pe   = rsum[63] ? (ne + 11'sh001) : ne;

   // underflow flushes to zero, overflow keeps the wrapped exponent
   assign res_zero = nz || (pe < EXP_MIN_NZ);
   assign res_ovf  = !res_zero && (pe > EXP_MAX);
   // RULE9 add bias
   assign pfield   = 8'(pe + EXP_BIAS);
   // RULE8 word layout
   assign pk_hi    = res_zero ? 32'h0 : {rs_q, pfield, pf[61:39]};
   // RULE7 double low word
   assign pk_lo    = (res_zero || !dbl) ? 32'h0 : pf[38:7];

   assign cc_load = ((state_q == S_NORM) || ((state_q == S_ARITH) && (op_q == OP_F2I)));

   // condition codes of the finishing operation
   always_comb begin
      if (state_q == S_ARITH) begin
         cc_new = {f2i_res[lng ? 31 : 15], (f2i_res == 32'h0), 1'b0, f2i_err};
      end else begin
         cc_new = {rs_q && !res_zero, res_zero, res_ovf || div0_q, 1'b0};
      end
   end

   // RULE15 result formats
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         res_hi_q <= 32'h0;
         res_lo_q <= 32'h0;
         done_q   <= 1'b0;
      end else begin
         done_q <= cc_load;
         if (state_q == S_NORM) begin
            // RULE14 hidden bit dropped
            res_hi_q <= pk_hi;
            res_lo_q <= pk_lo;
         end else if (cc_load) begin
            res_hi_q <= f2i_res;
            res_lo_q <= 32'h0;
         end
      end
   end

   assign rdata_o = rdata_q;
   assign busy_o  = (state_q != S_IDLE);
   assign done_o  = done_q;
   assign cc_o    = cc_q;

   // =================================================================
   // checks
   // =================================================================
   default clocking dflt_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b);

   a_norm_form_bits: assert property ( // RULE12
      (state_q == S_NORM) && !nz |-> (nf[63:62] == 2'b01))
      else $error("normalized fraction lacks hidden bit");

   a_norm_left_shift: assert property ( // RULE1
      (state_q == S_NORM) && !nz && !rf_q[63] |-> (nf == (rf_q << 6'(re_q - ne))))
      else $error("left shift count and exponent disagree");

   a_ovf_right_shift: assert property ( // RULE13
      (state_q == S_NORM) && rf_q[63] |-> (nf == (rf_q >> 1)) && (ne == re_q + 11'sh001))
      else $error("overflow not renormalized by one right shift");

   a_align_one_step: assert property ( // RULE2
      (state_q == S_ALIGN) && (fa_q != 64'h0) && (fb_q != 64'h0) && (ea_q < eb_q)
      |=> (ea_q == $past(ea_q) + 11'sh001) && (fa_q == ($past(fa_q) >> 1)))
      else $error("alignment step wrong");

   a_mul_exp_sum: assert property ( // RULE3
      (state_q == S_ARITH) && (op_q == OP_MUL) |=> (re_q == $past(ea_q) + $past(eb_q)))
      else $error("product exponent is not the sum");

   a_div_exp_diff: assert property ( // RULE4
      (state_q == S_ARITH) && (op_q == OP_DIV) |=> (re_q == $past(ea_q) - $past(eb_q)))
      else $error("quotient exponent is not the difference");

   a_zero_operand_mul: assert property ( // RULE10
      start && (wdata_i[2:0] == OP_MUL)
      && ((opa_hi_q[30:23] == 8'h00) || (opb_hi_q[30:23] == 8'h00))
      |-> ##3 cc_q[CC_Z] && (res_hi_q == 32'h0))
      else $error("zero exponent operand not treated as zero");

   a_hidden_reinsert: assert property ( // RULE14
      start && (wdata_i[2:0] == OP_ADD) && (opa_hi_q[30:23] != 8'h00)
      |=> (fa_q[63:62] == 2'b01))
      else $error("hidden bit not restored on unpack");

   a_sub_sign_flip: assert property ( // RULE11
      start && (wdata_i[2:0] == OP_SUB) |=> (sb_q == !$past(opb_hi_q[31])))
      else $error("subtract does not flip only the sign");

   a_trunc_pack: assert property ( // RULE19
      (state_q == S_NORM) && trunc && !res_zero |=> (res_hi_q[22:0] == $past(nf[61:39])))
      else $error("truncate mode altered fraction");

   c_align_done: cover property ((state_q == S_ALIGN) ##1 (state_q == S_ARITH));
   c_ovf_norm:   cover property ((state_q == S_NORM) && rf_q[63]);
   c_div_done:   cover property ((state_q == S_NORM) && (op_q == OP_DIV));
   c_f2i_error:  cover property ((state_q == S_ARITH) && (op_q == OP_F2I) && f2i_err);

endmodule : float_format_normalize_unit

// File: dv/host_model.sv
`timescale 1ns/100ps
// =====================================================================
// host side: master of the plain register port
// =====================================================================
module host_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] rdata_i,
   output logic      [4:0]  addr_o,
   output logic      [31:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   // bus idle from time zero
   initial begin
      addr_o  = 5'h00;
      wdata_o = 32'h0000_0000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // one-cycle write strobe, dropped after the edge that takes it
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask : rd_reg
endmodule : host_model

// File: dv/test_float_format_normalize_unit.sv
`timescale 1ns/100ps
// =====================================================================
// self-checking bench of the float format and normalize unit
// =====================================================================
module test_float_format_normalize_unit
   import fpu_pkg::*;
;
   localparam logic [31:0] ZW = 32'h0000_0000;
   logic        clk_i;
   logic        rst_b_i;
   logic [4:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        busy;
   logic        done;
   logic [3:0]  cc;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;

   host_model host (
      .clk_i   (clk_i),
      .rdata_i (rdata),
      .addr_o  (addr),
      .wdata_o (wdata),
      .wr_o    (wr),
      .rd_o    (rd)
   );

   float_format_normalize_unit uut (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .addr_i  (addr),
      .wdata_i (wdata),
      .wr_i    (wr),
      .rd_i    (rd),
      .rdata_o (rdata),
      .busy_o  (busy),
      .done_o  (done),
      .cc_o    (cc)
   );

   // =====================================================================
   // clock, timeout and verdict
   // =====================================================================
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // a run past 20000 cycles ends here; the done wait in run_op gives up after 200 cycles on its own
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // =====================================================================
   // comparison and operation helpers
   // =====================================================================
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask : check

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] want);
      logic [31:0] v;
      host.rd_reg(a, v);
      check(v, want);
   endtask : rd_chk

   // load operands, start, expect busy next cycle, then done, codes and result
   task automatic run_op(input logic [2:0] c, input logic [31:0] ah, al, bh, bl, rh, rl,
                         input logic [3:0] ecc);
      int n;
      host.wr_reg(OFF_OPA_HI, ah);
      host.wr_reg(OFF_OPA_LO, al);
      host.wr_reg(OFF_OPB_HI, bh);
      host.wr_reg(OFF_OPB_LO, bl);
      host.wr_reg(OFF_CMD, {29'h0, c});
      @(negedge clk_i);
      check({31'h0, busy}, 32'h0000_0001);
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      check({31'h0, done}, 32'h0000_0001);
      check({28'h000_0000, cc}, {28'h000_0000, ecc});
      rd_chk(OFF_RES_HI, rh);
      rd_chk(OFF_RES_LO, rl);
   endtask : run_op

   // =====================================================================
   // main sequence
   // =====================================================================
   initial begin
      rst_b_i = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      // status clear after reset, stored bits read back, spare bits zero
      rd_chk(OFF_STATUS, ZW);
      host.wr_reg(OFF_STATUS, 32'hFFFF_FFFF);
      rd_chk(OFF_STATUS, 32'h0000_4FEF);
      check({28'h000_0000, cc}, 32'h0000_000F);
      rd_chk(5'h02, ZW);
      host.wr_reg(OFF_STATUS, ZW);
      // single precision arithmetic, rounding on
      run_op(OP_ADD, 32'h4320_0000, ZW, 32'h41E0_0000, ZW, 32'h433C_0000, ZW, 4'h0);
      run_op(OP_ADD, 32'h4080_0000, ZW, 32'h4080_0000, ZW, 32'h4100_0000, ZW, 4'h0);
      run_op(OP_SUB, 32'h4040_0000, ZW, 32'h4080_0000, ZW, 32'hBF80_0000, ZW, 4'h8);
      run_op(OP_MUL, 32'h41E0_0000, ZW, 32'h4320_0000, ZW, 32'h448C_0000, ZW, 4'h0);
      run_op(OP_DIV, 32'h4270_0000, ZW, 32'h41A0_0000, ZW, 32'h4140_0000, ZW, 4'h0);
      // a zero divisor gives zero with the overflow code set
      run_op(OP_DIV, 32'h4080_0000, ZW, ZW, ZW, ZW, ZW, 4'h6);
      run_op(OP_ADD, 32'h007F_FFFF, ZW, 32'h4080_0000, ZW, 32'h4080_0000, ZW, 4'h0);
      run_op(OP_MUL, 32'h4080_0000, ZW, ZW, ZW, ZW, ZW, 4'h4);
      run_op(OP_ADD, 32'h4080_0000, ZW, 32'h3480_0000, ZW, 32'h4080_0001, ZW, 4'h0);
      // truncate mode drops the half lsb that rounding kept
      host.wr_reg(OFF_STATUS, 32'h0000_0020);
      run_op(OP_ADD, 32'h4080_0000, ZW, 32'h3480_0000, ZW, 32'h4080_0000, ZW, 4'h0);
      // conversions in short then long integer mode
      host.wr_reg(OFF_STATUS, ZW);
      run_op(OP_I2F, 32'h0000_FFFB, ZW, ZW, ZW, 32'hC1A0_0000, ZW, 4'h8);
      run_op(OP_I2F, 32'h0001_0000, ZW, ZW, ZW, ZW, ZW, 4'h4);
      run_op(OP_F2I, 32'hC1A0_0000, ZW, ZW, ZW, 32'h0000_FFFB, ZW, 4'h8);
      // 65536 does not fit a short integer: cleared result, carry set
      run_op(OP_F2I, 32'h4880_0000, ZW, ZW, ZW, ZW, ZW, 4'h5);
      host.wr_reg(OFF_STATUS, 32'h0000_0040);
      run_op(OP_I2F, 32'h0001_0000, ZW, ZW, ZW, 32'h4880_0000, ZW, 4'h0);
      run_op(OP_F2I, 32'hC1A0_0000, ZW, ZW, ZW, 32'hFFFF_FFFB, ZW, 4'h8);
      // double precision keeps the low fraction word
      host.wr_reg(OFF_STATUS, 32'h0000_0080);
      run_op(OP_ADD, 32'h4080_0000, 32'h0000_0001, 32'h4080_0000, 32'h0000_0001,
             32'h4100_0000, 32'h0000_0001, 4'h0);
      give_verdict();
   end
endmodule : test_float_format_normalize_unit
